//--- logic/pics_top.v
// Behaviour
// - Enables for parallel detect fault, partner ack, link-down, remote fault, link-up; reset 0.
// - Jabber flag bit 7 sets on jabber, clears when register is read.
// - Receive error flag bit 6 sets on error, clears on read.
// - Page received flag bit 5 sets on page, clears on read.
// - Parallel detect fault flag bit 4 sets on fault, clears on read.
// - Partner acknowledge flag bit 3 sets on event, clears on read.
// - Link-down flag bit 2 sets when link drops, clears on read.
// - Remote fault flag bit 1 sets on remote fault, clears on read.
// - Link-up flag bit 0 sets when link comes up, clears on read.
// - Interrupt pin active high when level bit 14 is 1, else active low.
// - Swap-off bit 6 set disables automatic crossover; reset leaves it enabled.
// - With automatic crossover off, select bit 7 picks MDI (1) or MDI-X (0).
// - Manual select bit is ignored while automatic crossover is enabled.
// - Jabber counter runs only while enable bit 9 is 1; resets to 1.
// - Resolved speed shown one-hot in bits 6, 5, 4 for 1000, 100, 10.
// - Resolved duplex shown in bit 3: 1 full, 0 half.
// - Enables for jabber, receive error, page received in bits 15..13; reset 0.
// - Read-cleared bits return value then clear; latched bits hold until cleared.
`timescale 1ns/100ps
`include "pics_regs.vh"

module pics_top #(
   parameter [4:0]  PHY_ADDR      = 5'h01,
   parameter        JAB_W         = 20,
   parameter [19:0] JABBER_CYCLES = 20'd100000
) (
   input  wire       clock,
   input  wire       arst_n,
   // Management pins
   input  wire       mdc,
   input  wire       mdio_i,
   output wire       mdio_o,
   output wire       mdio_oe,
   // Events from the transceiver core
   input  wire       tx_active,
   input  wire       ev_rx_error,
   input  wire       ev_page_rx,
   input  wire       ev_pd_fault,
   input  wire       ev_lp_ack,
   input  wire       ev_link_down,
   input  wire       ev_remote_fault,
   input  wire       ev_link_up,
   // Resolved link state from the core
   input  wire       speed_1000,
   input  wire       speed_100,
   input  wire       speed_10,
   input  wire       duplex_full,
   input  wire       auto_mdi_resolved,
   // Control outputs
   output wire       auto_crossover_en,
   output wire       crossover_mdi,
   output wire       jabber_count_en,
   output wire       int_pin
);

   localparam [2:0] S_PRE  = 3'h0;
   localparam [2:0] S_ST   = 3'h1;
   localparam [2:0] S_HDR  = 3'h2;
   localparam [2:0] S_TA   = 3'h3;
   localparam [2:0] S_DATA = 3'h4;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisation and clock edge detection
   wire [1:0] pin_s;
   wire       mdc_s;
   wire       mdio_s;
   reg        mdc_prev_q;
   wire       mdc_rise;

   pics_sync #(
      .W (2)
   ) u_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .d      ({mdc, mdio_i}),
      .q      (pin_s)
   );

   assign mdc_s  = pin_s[1];
   assign mdio_s = pin_s[0];

   // Edge seen on the synchronised copy only
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mdc_prev_q <= 1'b0;
      end else begin
         mdc_prev_q <= mdc_s;
      end
   end

   assign mdc_rise = mdc_s & ~mdc_prev_q;

   ////////////////////////////////////////////////////////////////////
   // Register state
   reg  [7:0]           int_en_q;
   reg  [15:0]          mdix_q;
   reg  [15:0]          phyctl_q;
   wire [`PICS_EV_W-1:0] ev_set;
   wire [`PICS_EV_W-1:0] status;
   reg  [`PICS_EV_W-1:0] rd_clr_q;
   wire                 jab_ev;

   // Read value of one register
   function [15:0] read_value;
      input [4:0]  addr;
      input [7:0]  en;
      input [7:0]  st;
      input [15:0] mdix;
      input [15:0] ctl;
      input [3:0]  spd_dup;
      begin
         case (addr)
            `PICS_REG_INT: begin
               read_value = {en, st};
            end
            `PICS_REG_MDIX: begin
               read_value = mdix;
            end
            `PICS_REG_PHYCTL: begin
               read_value = (ctl & `PICS_PHYCTL_WMASK) | {9'h000, spd_dup, 3'h0};
            end
            default: begin
               read_value = `PICS_ZERO16;
            end
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Management frame engine
   reg  [2:0]  state_q;
   reg  [5:0]  pre_cnt_q;
   reg  [3:0]  bit_cnt_q;
   reg  [10:0] hdr_q;
   reg  [15:0] sh_q;
   reg         rd_q;
   reg         wr_q;
   reg  [4:0]  reg_addr_q;
   reg         mdio_o_q;
   reg         mdio_oe_q;
   reg         wr_stb_q;
   reg  [15:0] wr_data_q;
   wire [11:0] hdr_full;
   wire        phy_hit;

   assign hdr_full = {hdr_q, mdio_s};
   assign phy_hit  = (hdr_full[9:5] == PHY_ADDR);

   // Bits are sampled and driven only on a rising MDC edge
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q    <= S_PRE;
         pre_cnt_q  <= 6'h00;
         bit_cnt_q  <= 4'h0;
         hdr_q      <= 11'h000;
         sh_q       <= 16'h0000;
         rd_q       <= 1'b0;
         wr_q       <= 1'b0;
         reg_addr_q <= 5'h00;
         mdio_o_q   <= 1'b0;
         mdio_oe_q  <= 1'b0;
         wr_stb_q   <= 1'b0;
         wr_data_q  <= 16'h0000;
         rd_clr_q   <= 8'h00;
      end else begin
         wr_stb_q <= 1'b0;
         rd_clr_q <= 8'h00;
         if (mdc_rise) begin
            case (state_q)
               S_PRE: begin
                  if (mdio_s) begin
                     if (pre_cnt_q != `PICS_PRE_LEN) begin
                        pre_cnt_q <= pre_cnt_q + 6'h01;
                     end
                  end else if (pre_cnt_q == `PICS_PRE_LEN) begin
                     state_q <= S_ST;
                  end else begin
                     pre_cnt_q <= 6'h00;
                  end
               end
               S_ST: begin
                  pre_cnt_q <= 6'h00;
                  bit_cnt_q <= 4'h0;
                  state_q   <= mdio_s ? S_HDR : S_PRE;
               end
               S_HDR: begin
                  hdr_q     <= hdr_full[10:0];
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == `PICS_HDR_LAST) begin
                     state_q    <= S_TA;
                     bit_cnt_q  <= 4'h0;
                     reg_addr_q <= hdr_full[4:0];
                     rd_q       <= phy_hit && (hdr_full[11:10] == `PICS_OP_RD);
                     wr_q       <= phy_hit && (hdr_full[11:10] == `PICS_OP_WR);
                     if (phy_hit && (hdr_full[11:10] == `PICS_OP_RD)) begin
                        sh_q <= read_value(hdr_full[4:0], int_en_q, status, mdix_q, phyctl_q,
                                           {speed_1000, speed_100, speed_10, duplex_full});
                        // Clear exactly the flags handed out
                        if (hdr_full[4:0] == `PICS_REG_INT) begin
                           rd_clr_q <= status;
                        end
                     end
                  end
               end
               S_TA: begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == 4'h0) begin
                     // Second turnaround bit driven low on reads
                     mdio_oe_q <= rd_q;
                     mdio_o_q  <= 1'b0;
                  end else begin
                     state_q   <= S_DATA;
                     bit_cnt_q <= 4'h0;
                     mdio_o_q  <= sh_q[15];
                     sh_q      <= {sh_q[14:0], 1'b0};
                  end
               end
               S_DATA: begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (rd_q) begin
                     mdio_o_q <= sh_q[15];
                     sh_q     <= {sh_q[14:0], 1'b0};
                  end else begin
                     sh_q <= {sh_q[14:0], mdio_s};
                  end
                  if (bit_cnt_q == `PICS_DATA_LAST) begin
                     state_q   <= S_PRE;
                     pre_cnt_q <= 6'h00;
                     mdio_oe_q <= 1'b0;
                     mdio_o_q  <= 1'b0;
                     rd_q      <= 1'b0;
                     wr_q      <= 1'b0;
                     wr_stb_q  <= wr_q;
                     wr_data_q <= {sh_q[14:0], mdio_s};
                  end
               end
               default: begin
                  state_q   <= S_PRE;
                  pre_cnt_q <= 6'h00;
                  mdio_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   assign mdio_o  = mdio_o_q;
   assign mdio_oe = mdio_oe_q;

   ////////////////////////////////////////////////////////////////////
   // Writable registers
   // Read-only bits are masked off so software cannot fake status
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         int_en_q <= `PICS_INT_EN_RST;
         mdix_q   <= `PICS_MDIX_RST;
         phyctl_q <= `PICS_PHYCTL_RST;
      end else if (wr_stb_q) begin
         case (reg_addr_q)
            `PICS_REG_INT: begin
               int_en_q <= wr_data_q[`PICS_INT_EN_MSB:`PICS_INT_EN_LSB];
            end
            `PICS_REG_MDIX: begin
               mdix_q <= wr_data_q;
            end
            `PICS_REG_PHYCTL: begin
               phyctl_q <= wr_data_q & `PICS_PHYCTL_WMASK;
            end
            default: begin
               int_en_q <= int_en_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Jabber counter
   reg [JAB_W-1:0] jab_cnt_q;
   reg             jab_ev_q;

   assign jabber_count_en = phyctl_q[`PICS_PHYCTL_JAB_EN];

   // Counter halts and clears when disabled; one event per long burst
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         jab_cnt_q <= {JAB_W{1'b0}};
         jab_ev_q  <= 1'b0;
      end else begin
         jab_ev_q <= 1'b0;
         if (!jabber_count_en || !tx_active) begin
            jab_cnt_q <= {JAB_W{1'b0}};
         end else if (jab_cnt_q != JABBER_CYCLES) begin
            jab_cnt_q <= jab_cnt_q + {{(JAB_W-1){1'b0}}, 1'b1};
            jab_ev_q  <= (jab_cnt_q == JABBER_CYCLES - {{(JAB_W-1){1'b0}}, 1'b1});
         end
      end
   end

   assign jab_ev = jab_ev_q;

   ////////////////////////////////////////////////////////////////////
   // Event flags, set whatever the enables say
   assign ev_set = {jab_ev,
                    ev_rx_error,
                    ev_page_rx,
                    ev_pd_fault,
                    ev_lp_ack,
                    ev_link_down,
                    ev_remote_fault,
                    ev_link_up};

   pics_sticky #(
      .W (`PICS_EV_W)
   ) u_flags (
      .clock  (clock),
      .arst_n (arst_n),
      .set    (ev_set),
      .clr    (rd_clr_q),
      .q      (status)
   );

   ////////////////////////////////////////////////////////////////////
   // Interrupt pin with selectable polarity
   reg  int_q;
   wire irq_any;

   assign irq_any = |(status & int_en_q);

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         int_q <= 1'b1;
      end else begin
         int_q <= phyctl_q[`PICS_PHYCTL_IRQ_LVL] ? irq_any : ~irq_any;
      end
   end

   assign int_pin = int_q;

   ////////////////////////////////////////////////////////////////////
   // Crossover control
   reg mdi_q;

   assign auto_crossover_en = ~mdix_q[`PICS_MDIX_SWAP_OFF];

   // Manual select only counts with swap-off set
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mdi_q <= 1'b0;
      end else if (mdix_q[`PICS_MDIX_SWAP_OFF]) begin
         mdi_q <= mdix_q[`PICS_MDIX_SEL];
      end else begin
         mdi_q <= auto_mdi_resolved;
      end
   end

   assign crossover_mdi = mdi_q;

   // Speed and duplex reach software only through read_value, never stored

endmodule

//--- logic/pics_regs.vh
`ifndef PICS_REGS_VH
`define PICS_REGS_VH

// Management register addresses
`define PICS_REG_INT        5'h1b
`define PICS_REG_MDIX       5'h1c
`define PICS_REG_PHYCTL     5'h1f

// Interrupt control/status layout
`define PICS_EV_W           8
`define PICS_INT_EN_MSB     15
`define PICS_INT_EN_LSB     8
`define PICS_INT_EN_RST     8'h00
`define PICS_INT_ST_RST     8'h00

// Crossover control layout
`define PICS_MDIX_RST       16'h0000
`define PICS_MDIX_SEL       7
`define PICS_MDIX_SWAP_OFF  6

// PHY control layout
`define PICS_PHYCTL_RST     16'h0200
`define PICS_PHYCTL_WMASK   16'hf382
`define PICS_PHYCTL_IRQ_LVL 14
`define PICS_PHYCTL_JAB_EN  9
`define PICS_PHYCTL_SPD1000 6
`define PICS_PHYCTL_SPD100  5
`define PICS_PHYCTL_SPD10   4
`define PICS_PHYCTL_DUPLEX  3

// Management frame
`define PICS_PRE_LEN        6'd32
`define PICS_OP_RD          2'b10
`define PICS_OP_WR          2'b01
`define PICS_HDR_LAST       4'd11
`define PICS_DATA_LAST      4'd15
`define PICS_ZERO16         16'h0000

`endif

//--- logic/pics_sync.v
`timescale 1ns/100ps
// Two-flop synchroniser for pin inputs
module pics_sync #(
   parameter W = 1
) (
   input  wire         clock,
   input  wire         arst_n,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule

//--- logic/pics_sticky.v
`timescale 1ns/100ps
// Latch-high event flags with read-clear
module pics_sticky #(
   parameter W = 8
) (
   input  wire         clock,
   input  wire         arst_n,
   input  wire [W-1:0] set,
   input  wire [W-1:0] clr,
   output wire [W-1:0] q
);

   reg [W-1:0] flag_q;
   wire [W-1:0] flag_d;

   // Set wins over a clear in the same cycle, so no event is lost
   assign flag_d = (flag_q & ~clr) | set;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= {W{1'b0}};
      end else begin
         flag_q <= flag_d;
      end
   end

   assign q = flag_q;

endmodule

//--- verification/pics_mgmt_model.sv
`timescale 1ns/100ps
`include "pics_regs.vh"
////////////////////////////////////////////////////////////////
// Station manager: frames on MDC/MDIO, MDIO line has a pull-up
module pics_mgmt_model (
   input  wire clock,
   output reg  mdc,
   output wire mdio_i,
   input  wire mdio_o,
   input  wire mdio_oe
);
   reg drv_oe;
   reg drv;

   // Wire level from both drivers; a released line floats high
   assign mdio_i = mdio_oe ? mdio_o : (drv_oe ? drv : 1'b1);

   // Clock stands low between frames
   initial begin
      mdc = 1'b0;
      drv_oe = 1'b0;
      drv = 1'b1;
   end

   // One frame, four system clocks per MDC phase; reads sampled just before a rise
   task frame(input [1:0] op, input [4:0] phy, input [4:0] ra, input [15:0] wd, output [15:0] rd);
      reg [63:0] bits;
      integer    k;
      begin
         bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
         rd = 16'h0000;
         for (k = 0; k < 64; k = k + 1) begin
            drv_oe = !(op == `PICS_OP_RD && k >= 46);
            drv = bits[63-k];
            repeat (4) @(negedge clock);
            if (k >= 48) rd = {rd[14:0], mdio_i};
            mdc = 1'b1;
            repeat (4) @(negedge clock);
            mdc = 1'b0;
         end
         drv_oe = 1'b0;
         repeat (8) @(negedge clock);
      end
   endtask
endmodule

//--- verification/pics_asserts.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// Port checks; state outputs may only move shortly after pin activity
module pics_asserts (
   input wire clock,
   input wire arst_n,
   input wire mdc,
   input wire mdio_o,
   input wire mdio_oe,
   input wire tx_active,
   input wire ev_rx_error,
   input wire ev_page_rx,
   input wire ev_pd_fault,
   input wire ev_lp_ack,
   input wire ev_link_down,
   input wire ev_remote_fault,
   input wire ev_link_up,
   input wire auto_mdi_resolved,
   input wire auto_crossover_en,
   input wire crossover_mdi,
   input wire jabber_count_en,
   input wire int_pin
);
   reg  [3:0] quiet_q;
   reg  [8:0] act_q;
   wire [8:0] act = {mdc, tx_active, ev_rx_error, ev_page_rx, ev_pd_fault, ev_lp_ack,
                     ev_link_down, ev_remote_fault, ev_link_up};

   // Cycles since last activity, saturating; event levels count as activity
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         quiet_q <= 4'h0;
         act_q <= 9'h000;
      end else begin
         act_q <= act;
         if (act != act_q || |act[7:0]) quiet_q <= 4'h0;
         else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // Read answer: turnaround zero, then drive held for seven more cycles
   sequence s_ta_drive;
      !mdio_o ##1 mdio_oe [*7];
   endsequence

   chk_reset_idle: assert property ($rose(arst_n) |-> int_pin && auto_crossover_en && jabber_count_en)
      else $error("outputs not idle after reset");
   chk_auto_follow: assert property (auto_crossover_en |=> crossover_mdi == $past(auto_mdi_resolved))
      else $error("auto crossover result not followed");
   chk_manual_hold: assert property (!auto_crossover_en && quiet_q > 4'd10 |=> $stable(crossover_mdi))
      else $error("manual crossover moved without a write");
   chk_int_cause: assert property ($changed(int_pin) |-> quiet_q < 4'd12)
      else $error("interrupt moved with no cause");
   chk_jab_cause: assert property ($changed(jabber_count_en) |-> quiet_q < 4'd12)
      else $error("jabber enable moved with no write");
   chk_auto_cause: assert property ($changed(auto_crossover_en) |-> quiet_q < 4'd12)
      else $error("crossover enable moved with no write");
   chk_ta_drive: assert property ($rose(mdio_oe) |-> s_ta_drive)
      else $error("read turnaround wrong");
   chk_oe_cause: assert property ($rose(mdio_oe) |-> quiet_q < 4'd8)
      else $error("drive started away from a clock rise");
   chk_data_step: assert property ($changed(mdio_o) && mdio_oe |-> quiet_q < 4'd8)
      else $error("read data moved away from a clock rise");
endmodule

bind pics_top pics_asserts u_chk (
   .clock(clock), .arst_n(arst_n), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
   .tx_active(tx_active), .ev_rx_error(ev_rx_error), .ev_page_rx(ev_page_rx),
   .ev_pd_fault(ev_pd_fault), .ev_lp_ack(ev_lp_ack), .ev_link_down(ev_link_down),
   .ev_remote_fault(ev_remote_fault), .ev_link_up(ev_link_up),
   .auto_mdi_resolved(auto_mdi_resolved), .auto_crossover_en(auto_crossover_en),
   .crossover_mdi(crossover_mdi), .jabber_count_en(jabber_count_en), .int_pin(int_pin)
);

//--- verification/test_phy_interrupt_crossover_status.sv
`timescale 1ns/100ps
`include "pics_regs.vh"
////////////////////////////////////////////////////////////////
module test_phy_interrupt_crossover_status;
   localparam [4:0] PHY = 5'h01;
   localparam       JAB = 20;
   reg         clock, arst_n, tx_active, auto_mdi_resolved;
   reg  [6:0]  ev;
   reg  [3:0]  sd;
   reg  [15:0] v, en, fl, ctl;
   reg  [31:0] seed;
   wire        mdc, mdio_i, mdio_o, mdio_oe, auto_crossover_en, crossover_mdi, jabber_count_en, int_pin;
   integer     n_errors, checks_done, i;

   // Short jabber count keeps the run brief
   pics_top #(.PHY_ADDR(PHY), .JAB_W(20), .JABBER_CYCLES(20'd20)) DUT (
      .clock(clock), .arst_n(arst_n), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
      .tx_active(tx_active), .ev_rx_error(ev[6]), .ev_page_rx(ev[5]), .ev_pd_fault(ev[4]),
      .ev_lp_ack(ev[3]), .ev_link_down(ev[2]), .ev_remote_fault(ev[1]), .ev_link_up(ev[0]),
      .speed_1000(sd[3]), .speed_100(sd[2]), .speed_10(sd[1]), .duplex_full(sd[0]),
      .auto_mdi_resolved(auto_mdi_resolved), .auto_crossover_en(auto_crossover_en),
      .crossover_mdi(crossover_mdi), .jabber_count_en(jabber_count_en), .int_pin(int_pin));

   pics_mgmt_model u_mgmt (.clock(clock), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));

   ////////////////////////////////////////////////////////////////
   // Helpers: random source, expectations, comparisons, bus cycles
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic exp_int(input [7:0] f, input [7:0] e, input lvl);
      return lvl ? |(f & e) : ~|(f & e);
   endfunction
   function automatic logic exp_mdi(input [15:0] x, input a);
      return x[6] ? x[7] : a;
   endfunction
   task chk16(input [15:0] got, input [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
      end
   endtask
   task chk1(input got, input exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[FAIL] %0t pin %b expected %b", $time, got, exp);
      end
   endtask
   task rd(input [4:0] a, input [15:0] e);
      reg [15:0] r;
      u_mgmt.frame(`PICS_OP_RD, PHY, a, 16'h0000, r);
      chk16(r, e);
   endtask
   task wr(input [4:0] a, input [15:0] d);
      reg [15:0] r;
      u_mgmt.frame(`PICS_OP_WR, PHY, a, d, r);
   endtask
   task results;
      if (n_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   // Free-running clock, hang guard
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      #1500000;
      n_errors = n_errors + 1;
      $display("[FAIL] %0t run did not finish", $time);
      results;
   end

   // Main sequence
   initial begin
      n_errors = 0; checks_done = 0; seed = 32'd53;
      arst_n = 1'b0; tx_active = 1'b0; ev = 7'h00; sd = 4'h0; auto_mdi_resolved = 1'b0;
      repeat (2) @(negedge clock);
      arst_n = 1'b1;
      repeat (4) @(negedge clock);
      chk1(int_pin, 1'b1);
      chk1(auto_crossover_en, 1'b1);
      chk1(jabber_count_en, 1'b1);
      rd(`PICS_REG_INT, 16'h0000);
      rd(`PICS_REG_MDIX, 16'h0000);
      rd(`PICS_REG_PHYCTL, 16'h0200);
      rd(5'h05, 16'h0000);
      u_mgmt.frame(`PICS_OP_RD, 5'h02, `PICS_REG_INT, 16'h0000, v);
      chk16(v, 16'hffff);
      // Events with random enables and pin level; first round adds a jabber
      for (i = 0; i < 3; i = i + 1) begin
         en = 16'(xs());
         fl = 16'(xs()) & 16'h007f;
         ctl = (16'(xs()) & `PICS_PHYCTL_WMASK) | 16'h0200;
         wr(`PICS_REG_PHYCTL, ctl);
         wr(`PICS_REG_INT, en);
         ev = fl[6:0];
         @(negedge clock) ev = 7'h00;
         if (i == 0) begin
            tx_active = 1'b1;
            repeat (JAB + 3) @(negedge clock);
            tx_active = 1'b0;
            fl[7] = 1'b1;
         end
         repeat (3) @(negedge clock);
         chk1(int_pin, exp_int(fl[7:0], en[15:8], ctl[14]));
         rd(`PICS_REG_INT, {en[15:8], fl[7:0]});
         chk1(int_pin, exp_int(8'h00, en[15:8], ctl[14]));
         rd(`PICS_REG_INT, {en[15:8], 8'h00});
         sd = {3'b100 >> i, fl[0]};
         rd(`PICS_REG_PHYCTL, ctl | {9'h000, sd, 3'h0});
      end
      // Jabber counting switched off
      wr(`PICS_REG_PHYCTL, 16'h0000);
      chk1(jabber_count_en, 1'b0);
      chk1(int_pin, 1'b1);
      tx_active = 1'b1;
      repeat (JAB + 5) @(negedge clock);
      tx_active = 1'b0;
      rd(`PICS_REG_INT, {en[15:8], 8'h00});
      // Crossover: all four select/swap-off codes, then random words
      for (i = 0; i < 6; i = i + 1) begin
         v = (i < 4) ? {8'h00, i[1:0], 6'h00} : 16'(xs());
         wr(`PICS_REG_MDIX, v);
         rd(`PICS_REG_MDIX, v);
         repeat (16) @(negedge clock);
         auto_mdi_resolved = ~auto_mdi_resolved;
         repeat (2) @(negedge clock);
         chk1(auto_crossover_en, ~v[6]);
         chk1(crossover_mdi, exp_mdi(v, auto_mdi_resolved));
      end
      // Reset in mid-run brings written registers back to defaults
      arst_n = 1'b0;
      repeat (2) @(negedge clock);
      arst_n = 1'b1;
      repeat (4) @(negedge clock);
      chk1(jabber_count_en, 1'b1);
      chk1(auto_crossover_en, 1'b1);
      rd(`PICS_REG_MDIX, 16'h0000);
      rd(`PICS_REG_INT, 16'h0000);
      results;
   end
endmodule
